// *** hdl/dac_ctrl_pkg.sv ***
// package of constants and types for the converter pin control block
package dac_ctrl_pkg;
    localparam int CHANNELS      = 16;
    localparam int CODE_W        = 16;
    localparam int SPAN_W        = 3;
    localparam int TOGGLE_PINS   = 3;
    localparam int SEL_W         = 2;
    localparam int SYNC_STAGES   = 2;
    localparam logic [CODE_W-1:0] ZERO_CODE  = 16'h0000;
    localparam logic [SPAN_W-1:0] SPAN_0_5V  = 3'h0;
    localparam logic [CHANNELS-1:0] EN_DEFAULT = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_DEFAULT = 2'h0;
    localparam logic [1:0] MODE_TOGGLE = 2'h1;
    localparam logic [1:0] MODE_DITHER = 2'h2;
    localparam logic [1:0] MODE_OFF    = 2'h0;
    typedef logic [CODE_W-1:0] code_t;
    typedef logic [SPAN_W-1:0] span_t;
    typedef enum logic [2:0] {
        ST_RUN   = 3'h1,
        ST_CLEAR = 3'h2,
        ST_BOOT  = 3'h4
    } ctrl_state_t;
endpackage

// *** hdl/dac_toggle_clear_fault_ctrl.sv ***
// pin-level control of toggles, clear, update, fault and reference select
//
// Functional notes
// - toggle fall loads register A
// - toggle rise loads register B
// - dither mode updates only on rise
// - only enabled channels follow toggle pins
// - clear level forces zero code, 0-5 span
// - clear restores control registers to defaults
// - fault pulls open-drain output low
// - overtemperature or serial error raises fault
// - load strobe rise releases fault output
// - internal reference drives pin by default
// - external mode disconnects reference, pin input
// - grounded compensation pin disables internal reference
// - strobe high ends shifting, executes command
// - update fall with strobe high loads all
`timescale 1ns/1ps
`default_nettype none
module dac_toggle_clear_fault_ctrl (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // asynchronous control pins
    input  wire logic [dac_ctrl_pkg::TOGGLE_PINS-1:0] toggle_pin,
    input  wire logic async_clear_n,
    input  wire logic async_update_n,
    input  wire logic select_load_n,
    input  wire logic reference_comp_pin,
    // configuration from the serial command decoder
    input  wire logic [1:0] mode,
    input  wire logic [dac_ctrl_pkg::CHANNELS-1:0] en_wdata,
    input  wire logic en_we,
    input  wire logic [dac_ctrl_pkg::CHANNELS*2-1:0] sel_wdata,
    input  wire logic sel_we,
    input  wire logic ext_ref_wdata,
    input  wire logic ext_ref_we,
    // input registers and command results
    input  wire logic [dac_ctrl_pkg::CHANNELS*16-1:0] input_a,
    input  wire logic [dac_ctrl_pkg::CHANNELS*16-1:0] input_b,
    input  wire logic cmd_update_all,
    input  wire logic [dac_ctrl_pkg::CHANNELS*3-1:0] span_wdata,
    input  wire logic span_we,
    // fault sources
    input  wire logic over_temp,
    input  wire logic serial_error,
    // outputs
    output logic [dac_ctrl_pkg::CHANNELS*16-1:0] out_code,
    output logic [dac_ctrl_pkg::CHANNELS*3-1:0]  out_span,
    output logic [dac_ctrl_pkg::CHANNELS-1:0]    toggle_dither_enable_bit,
    output logic fault_out,
    output logic fault_oe,
    output logic internal_ref_on,
    output logic ref_pin_oe
);
    import dac_ctrl_pkg::*;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [TOGGLE_PINS-1:0] tg_rise, tg_fall;
    logic clr_lvl, upd_fall, cs_lvl, cs_rise;
    logic comp_lvl;

    genvar g;
    generate
        for (g = 0; g < TOGGLE_PINS; g++) begin : g_tg
            pin_sync u_tg (.clock(clock), .rst_n(rst_n), .reset_level(1'b0),
                .pin(toggle_pin[g]), .level(),
                .rise(tg_rise[g]), .fall(tg_fall[g]));
        end
    endgenerate
    pin_sync u_clr (.clock(clock), .rst_n(rst_n), .reset_level(1'b1),
        .pin(async_clear_n), .level(clr_lvl),
        .rise(), .fall());
    pin_sync u_upd (.clock(clock), .rst_n(rst_n), .reset_level(1'b1),
        .pin(async_update_n), .level(),
        .rise(), .fall(upd_fall));
    pin_sync u_cs (.clock(clock), .rst_n(rst_n), .reset_level(1'b1),
        .pin(select_load_n), .level(cs_lvl),
        .rise(cs_rise), .fall());
    pin_sync u_comp (.clock(clock), .rst_n(rst_n), .reset_level(1'b1),
        .pin(reference_comp_pin), .level(comp_lvl),
        .rise(), .fall());

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    // the strap needs both sync stages filled before it can be trusted
    localparam logic [1:0] BOOT_LAST = 2'(SYNC_STAGES);
    ctrl_state_t state, next_state;
    logic [1:0] boot_cnt, next_boot_cnt;
    logic [CHANNELS-1:0]   next_en;
    logic [CHANNELS*2-1:0] sel, next_sel;
    logic ext_ref, next_ext_ref;
    logic comp_strap, next_comp_strap;
    logic [CHANNELS*16-1:0] next_code;
    logic [CHANNELS*3-1:0]  next_span;
    logic fault, next_fault, next_fault_oe, next_int_ref, next_ref_oe;
    logic [TOGGLE_PINS-1:0] sel_rise, sel_fall;
    logic do_a, do_b;
    code_t ca, cb;

    // picks which toggle pin a channel listens to
    function automatic logic pin_hit(input logic [TOGGLE_PINS-1:0] ev,
                                     input logic [1:0] s);
        pin_hit = (s < TOGGLE_PINS) ? ev[s] : 1'b0;
    endfunction

    always_comb begin
        next_state      = state;
        next_boot_cnt   = boot_cnt;
        next_en         = toggle_dither_enable_bit;
        next_sel        = sel;
        next_ext_ref    = ext_ref;
        next_comp_strap = comp_strap;
        next_code       = out_code;
        next_span       = out_span;
        next_fault      = fault;
        sel_rise        = tg_rise;
        sel_fall        = tg_fall;
        do_a            = 1'b0;
        do_b            = 1'b0;
        ca              = ZERO_CODE;
        cb              = ZERO_CODE;
        case (state)
            ST_BOOT: begin
                // strap caught once it has crossed the synchroniser
                next_boot_cnt = boot_cnt + 2'h1;
                if (boot_cnt == BOOT_LAST) begin
                    next_comp_strap = comp_lvl;
                    next_state      = ST_RUN;
                end
            end
            ST_CLEAR: begin
                if (clr_lvl)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (en_we)
                    next_en = en_wdata;
                if (sel_we)
                    next_sel = sel_wdata;
                if (ext_ref_we)
                    next_ext_ref = ext_ref_wdata;
                if (span_we)
                    next_span = span_wdata;
                // strobe high executes the shifted command
                if (cmd_update_all ||
                    (cs_lvl && upd_fall && !cs_rise))
                    next_code = input_a;
                for (int c = 0; c < CHANNELS; c++) begin
                    do_a = 1'b0;
                    do_b = 1'b0;
                    if (toggle_dither_enable_bit[c]) begin
                        if (mode == MODE_TOGGLE) begin
                            do_a = pin_hit(sel_fall, sel[c*2 +: 2]);
                            do_b = pin_hit(sel_rise, sel[c*2 +: 2]);
                        end else if (mode == MODE_DITHER) begin
                            // dither steps on the clock rise only
                            do_b = pin_hit(sel_rise, sel[c*2 +: 2]);
                        end
                    end
                    ca = input_a[c*16 +: 16];
                    cb = input_b[c*16 +: 16];
                    if (do_a)
                        next_code[c*16 +: 16] = ca;
                    if (do_b)
                        next_code[c*16 +: 16] = cb;
                end
            end
            default: next_state = ST_RUN;
        endcase
        // clear level overrides state, codes, spans and controls while low; the fault logic below is not affected
        if (!clr_lvl) begin
            next_state   = ST_CLEAR;
            next_code    = {CHANNELS{ZERO_CODE}};
            next_span    = {CHANNELS{SPAN_0_5V}};
            next_en      = EN_DEFAULT;
            next_sel     = {CHANNELS{SEL_DEFAULT}};
            next_ext_ref = 1'b0;
        end
        // a new fault beats the release in the same cycle
        if (cs_rise)
            next_fault = 1'b0;
        if (over_temp || serial_error)
            next_fault = 1'b1;
        // reference stays off until the strap is known, so no glitch
        next_int_ref  = !next_ext_ref && next_comp_strap
                        && (next_state != ST_BOOT);
        next_ref_oe   = !next_int_ref;
        next_fault_oe = !next_fault;
    end

    // registers only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state                    <= ST_BOOT;
            boot_cnt                 <= 2'h0;
            toggle_dither_enable_bit <= EN_DEFAULT;
            sel                      <= {CHANNELS{SEL_DEFAULT}};
            ext_ref                  <= 1'b0;
            comp_strap               <= 1'b1;
            out_code                 <= {CHANNELS{ZERO_CODE}};
            out_span                 <= {CHANNELS{SPAN_0_5V}};
            fault                    <= 1'b0;
            fault_oe                 <= 1'b1;
            internal_ref_on          <= 1'b0;
            ref_pin_oe               <= 1'b1;
        end else begin
            state                    <= next_state;
            boot_cnt                 <= next_boot_cnt;
            toggle_dither_enable_bit <= next_en;
            sel                      <= next_sel;
            ext_ref                  <= next_ext_ref;
            comp_strap               <= next_comp_strap;
            out_code                 <= next_code;
            out_span                 <= next_span;
            fault                    <= next_fault;
            fault_oe                 <= next_fault_oe;
            internal_ref_on          <= next_int_ref;
            ref_pin_oe               <= next_ref_oe;
        end
    end

    // open drain: output value is always low, only the enable moves
    always_ff @(posedge clock) begin
        fault_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_clear_zero: assert property (@(posedge clock)
        disable iff (!rst_n) !clr_lvl |=> out_code == {CHANNELS{ZERO_CODE}})
        else $error("clear did not zero codes");
    chk_clear_span: assert property (@(posedge clock)
        disable iff (!rst_n) !clr_lvl |=> out_span == {CHANNELS{SPAN_0_5V}})
        else $error("clear did not reset spans");
    chk_clear_ctrl: assert property (@(posedge clock)
        disable iff (!rst_n)
        !clr_lvl |=> toggle_dither_enable_bit == EN_DEFAULT && !ext_ref)
        else $error("clear did not reset controls");
    chk_fault_set: assert property (@(posedge clock)
        disable iff (!rst_n) (over_temp || serial_error) |=> !fault_oe)
        else $error("fault not signalled");
    chk_fault_free: assert property (@(posedge clock)
        disable iff (!rst_n)
        cs_rise && !over_temp && !serial_error |=> fault_oe)
        else $error("fault not released");
    // a clear or a rewrite to internal mode legally ends external mode
    chk_ref_ext: assert property (@(posedge clock)
        disable iff (!rst_n) ext_ref && state == ST_RUN && clr_lvl
        && !ext_ref_we |=> !internal_ref_on && ref_pin_oe)
        else $error("external reference not honoured");
    chk_ref_pair: assert property (@(posedge clock)
        disable iff (!rst_n) ref_pin_oe == !internal_ref_on)
        else $error("reference drive mismatch");
    chk_ref_default: assert property (@(posedge clock)
        disable iff (!rst_n) state == ST_RUN && !ext_ref && comp_strap
        && !ext_ref_we |=> internal_ref_on)
        else $error("internal reference not on by default");
    chk_strap_off: assert property (@(posedge clock)
        disable iff (!rst_n) state == ST_BOOT && boot_cnt == BOOT_LAST
        && !comp_lvl |=> !internal_ref_on && ref_pin_oe)
        else $error("grounded strap left reference on");
    chk_tg_off: assert property (@(posedge clock)
        disable iff (!rst_n) clr_lvl && state == ST_RUN
        && toggle_dither_enable_bit[0] == 1'b0 && !cmd_update_all
        && !upd_fall |=> $stable(out_code[15:0]))
        else $error("disabled channel moved");
    chk_toggle_a: assert property (@(posedge clock)
        disable iff (!rst_n) clr_lvl && state == ST_RUN
        && mode == MODE_TOGGLE && toggle_dither_enable_bit[0]
        && sel[1:0] == 2'h0 && tg_fall[0]
        |=> out_code[15:0] == $past(input_a[15:0]))
        else $error("toggle fall did not load register A");
    chk_toggle_b: assert property (@(posedge clock)
        disable iff (!rst_n) clr_lvl && state == ST_RUN
        && mode == MODE_TOGGLE && toggle_dither_enable_bit[0]
        && sel[1:0] == 2'h0 && tg_rise[0]
        |=> out_code[15:0] == $past(input_b[15:0]))
        else $error("toggle rise did not load register B");
    chk_dither_fall: assert property (@(posedge clock)
        disable iff (!rst_n) clr_lvl && state == ST_RUN
        && mode == MODE_DITHER && toggle_dither_enable_bit[0]
        && sel[1:0] == 2'h0 && tg_fall[0] && !cmd_update_all
        && !upd_fall |=> $stable(out_code[15:0]))
        else $error("dither moved on a falling clock");
endmodule
`default_nettype wire

// *** hdl/pin_sync.sv ***
// two-flop level synchroniser with combinational edge flags decoded from a third delay flop
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic reset_level,
    // pin and result
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic next_meta;
    logic next_level;
    logic prev;
    logic next_prev;

    // first stage feeds only the second stage
    always_comb begin
        next_meta  = pin;
        next_level = meta;
        next_prev  = level;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta  <= reset_level;
            level <= reset_level;
            prev  <= reset_level;
        end else begin
            meta  <= next_meta;
            level <= next_level;
            prev  <= next_prev;
        end
    end

    // edges come from the two stable stages only
    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule
`default_nettype wire

// *** sim/dac_toggle_clear_fault_ctrl_test.sv ***
// self-checking bench for the converter pin control block
`timescale 1ns/1ps
`default_nettype none
module dac_toggle_clear_fault_ctrl_test;
    import dac_ctrl_pkg::*;
    typedef struct { logic [1:0] md; logic tp; code_t exp; } row_t;
    logic clock, rst_n, clr_n, upd_n, cs_n, strap;
    logic [2:0] tp;
    logic [1:0] mode;
    logic en_we, sel_we, span_we, ext_ref_wdata, ext_ref_we;
    logic cmd_update_all, over_temp, serial_error;
    logic [15:0] en_wdata, tde;
    logic [31:0] sel_wdata;
    logic [47:0] span_wdata, out_span;
    logic [255:0] input_a, input_b, out_code;
    logic fault_out, fault_oe, internal_ref_on, ref_pin_oe;
    int num_errors, comparisons, cycles;
    row_t rows [8];
    host_pins u_host (.clock(clock), .toggle_pin(tp), .async_clear_n(clr_n),
        .async_update_n(upd_n), .select_load_n(cs_n),
        .reference_comp_pin(strap));
    dac_toggle_clear_fault_ctrl u_dut (.clock(clock), .rst_n(rst_n),
        .toggle_pin(tp), .async_clear_n(clr_n), .async_update_n(upd_n),
        .select_load_n(cs_n), .reference_comp_pin(strap), .mode(mode),
        .en_wdata(en_wdata), .en_we(en_we), .sel_wdata(sel_wdata),
        .sel_we(sel_we), .ext_ref_wdata(ext_ref_wdata),
        .ext_ref_we(ext_ref_we), .input_a(input_a), .input_b(input_b),
        .cmd_update_all(cmd_update_all), .span_wdata(span_wdata),
        .span_we(span_we), .over_temp(over_temp),
        .serial_error(serial_error), .out_code(out_code),
        .out_span(out_span), .toggle_dither_enable_bit(tde),
        .fault_out(fault_out), .fault_oe(fault_oe),
        .internal_ref_on(internal_ref_on), .ref_pin_oe(ref_pin_oe));
    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(string what, logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write strobes {ext_ref, span, sel, en}
    task automatic wr(input logic [3:0] m);
        @(negedge clock);
        {ext_ref_we, span_we, sel_we, en_we} = m;
        @(negedge clock);
        {ext_ref_we, span_we, sel_we, en_we} = 4'h0;
        repeat (3) @(negedge clock);
    endtask
    // reset is held five cycles; the wait covers the strap capture
    task automatic do_reset();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (5) @(negedge clock);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_n, mode, en_we, sel_we, span_we, ext_ref_we} = '0;
        {ext_ref_wdata, cmd_update_all, over_temp, serial_error} = '0;
        {num_errors, comparisons, cycles} = '0;
        en_wdata = 16'h0001;
        sel_wdata = 32'h0000_0000;
        span_wdata = {16{3'h2}};
        for (int c = 0; c < 16; c++) begin
            input_a[c*16+:16] = 16'hA000 + c[15:0];
            input_b[c*16+:16] = 16'hB000 + c[15:0];
        end
        rows = '{'{MODE_TOGGLE, 1'b1, 16'hB000}, '{MODE_TOGGLE, 1'b0, 16'hA000},
                 '{MODE_DITHER, 1'b1, 16'hB000}, '{MODE_DITHER, 1'b0, 16'hB000},
                 '{MODE_TOGGLE, 1'b1, 16'hB000}, '{MODE_TOGGLE, 1'b0, 16'hA000},
                 '{MODE_OFF, 1'b1, 16'hA000}, '{MODE_OFF, 1'b0, 16'hA000}};
        do_reset();
        check("code0", out_code[15:0], ZERO_CODE);
        check("fault_oe", fault_oe, 1'b1);
        check("iref", internal_ref_on, 1'b1);
        check("ref_oe", ref_pin_oe, 1'b0);
        wr(4'h7);
        check("span0", out_span[2:0], 3'h2);
        $display("test reset and config done");
        // only channel 0 is enabled; channel 1 must never move
        foreach (rows[i]) begin
            @(negedge clock);
            mode = rows[i].md;
            u_host.drive({2'h0, rows[i].tp}, 1'b1, 1'b1, 1'b1);
            check("toggled", out_code[15:0], rows[i].exp);
            check("idle ch", out_code[31:16], ZERO_CODE);
        end
        $display("test toggle table done");
        // update pin with strobe high loads every channel
        u_host.drive(3'h0, 1'b1, 1'b0, 1'b1);
        check("upd ch1", out_code[31:16], 16'hA001);
        u_host.drive(3'h0, 1'b1, 1'b1, 1'b1);
        input_a[15:0] = 16'hA5A5;
        @(negedge clock) cmd_update_all = 1'b1;
        @(negedge clock) cmd_update_all = 1'b0;
        repeat (3) @(negedge clock);
        check("cmd ch0", out_code[15:0], 16'hA5A5);
        $display("test update done");
        // both fault sources, released only by a strobe rise
        for (int k = 0; k < 2; k++) begin
            @(negedge clock) {serial_error, over_temp} = 2'h1 << k;
            repeat (4) @(negedge clock);
            check("fault on", fault_oe, 1'b0);
            check("fault lvl", fault_out, 1'b0);
            @(negedge clock) {serial_error, over_temp} = 2'h0;
            repeat (4) @(negedge clock);
            check("fault held", fault_oe, 1'b0);
            u_host.drive(3'h0, 1'b1, 1'b1, 1'b0);
            u_host.drive(3'h0, 1'b1, 1'b1, 1'b1);
            check("fault off", fault_oe, 1'b1);
        end
        $display("test fault done");
        ext_ref_wdata = 1'b1;
        wr(4'h8);
        check("ext iref", internal_ref_on, 1'b0);
        check("ext oe", ref_pin_oe, 1'b1);
        $display("test external reference done");
        // clear level wipes state and blocks writes while low
        u_host.drive(3'h0, 1'b0, 1'b1, 1'b1);
        en_wdata = 16'hFFFF;
        wr(4'h1);
        check("clr code", out_code[15:0], ZERO_CODE);
        check("clr span", out_span[2:0], SPAN_0_5V);
        check("clr en", tde, EN_DEFAULT);
        u_host.drive(3'h0, 1'b1, 1'b1, 1'b1);
        check("clr en after", tde, EN_DEFAULT);
        check("clr iref", internal_ref_on, 1'b1);
        $display("test clear done");
        // channel 0 moved to pin 1, then to no pin at all
        mode = MODE_TOGGLE;
        en_wdata = 16'h0001;
        sel_wdata = 32'h0000_0001;
        wr(4'h3);
        u_host.drive(3'h1, 1'b1, 1'b1, 1'b1);
        check("pin0 ignored", out_code[15:0], ZERO_CODE);
        u_host.drive(3'h2, 1'b1, 1'b1, 1'b1);
        check("pin1 rise", out_code[15:0], 16'hB000);
        u_host.drive(3'h0, 1'b1, 1'b1, 1'b1);
        check("pin1 fall", out_code[15:0], 16'hA5A5);
        sel_wdata = 32'h0000_0003;
        wr(4'h2);
        u_host.drive(3'h2, 1'b1, 1'b1, 1'b1);
        check("no pin", out_code[15:0], 16'hA5A5);
        u_host.drive(3'h0, 1'b1, 1'b1, 1'b1);
        $display("test pin select done");
        u_host.strap(1'b0);
        do_reset();
        check("strap iref", internal_ref_on, 1'b0);
        $display("test strap done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** sim/host_pins.sv ***
// host model that drives the converter's asynchronous control pins
`timescale 1ns/1ps
`default_nettype none
module host_pins (
    // clock
    input  wire logic       clock,
    // pins toward the device
    output var logic [2:0] toggle_pin,
    output var logic       async_clear_n,
    output var logic       async_update_n,
    output var logic       select_load_n,
    output var logic       reference_comp_pin
);
    // idle levels: toggles low, clear, update and strobe released
    initial begin
        toggle_pin         = 3'h0;
        async_clear_n      = 1'b1;
        async_update_n     = 1'b1;
        select_load_n      = 1'b1;
        reference_comp_pin = 1'b1;
    end
    // pins move after a falling edge; wait covers sync and update delay
    task automatic drive(input logic [2:0] tp, input logic clr_n,
                         input logic upd_n, input logic cs_n);
        @(negedge clock);
        toggle_pin     = tp;
        async_clear_n  = clr_n;
        async_update_n = upd_n;
        select_load_n  = cs_n;
        repeat (6) @(negedge clock);
    endtask
    // strap level only matters across a reset
    task automatic strap(input logic v);
        reference_comp_pin = v;
    endtask
endmodule
`default_nettype wire
